//--- dtmf_line_model.sv
// line side model: limited low and high group tone pair for the receiver
// assumes the comparators give clean square waves; off-band chatter between bursts
`timescale 1ns/1ps
module dtmf_line_model (
   // tone control
   input  wire logic        i_on,
   input  wire logic [15:0] i_low_hz,
   input  wire logic [15:0] i_high_hz,
   // limited tone outputs
   output logic             o_low_tone,
   output logic             o_high_tone
);
   // out of band chatter while no pair is sent, so stale periods end quickly
   localparam real OFF_HZ = 50000.0;
   function automatic real half_ns(input logic [15:0] f);
      return 1.0e9 / (2.0 * (i_on ? real'(f) : OFF_HZ));
   endfunction
   always begin : low_gen
      o_low_tone = 1'b1;
      #(half_ns(i_low_hz));
      o_low_tone = 1'b0;
      #(half_ns(i_low_hz));
   end
   always begin : high_gen
      o_high_tone = 1'b1;
      #(half_ns(i_high_hz));
      o_high_tone = 1'b0;
      #(half_ns(i_high_hz));
   end
   // restart both tones from the start of the high half on every burst change
   always @(i_on) begin
      disable low_gen;
      disable high_gen;
   end
endmodule

//--- dtmf_rx_decode_steering.sv
// tone pair decode, early and delayed steering, receive register and bus
// assumes comparator tone inputs asynchronous; bus from same-clock logic
// Functional notes
// - measure each tone period by counting; accept only near standard frequencies
// - map low/high pair to 4-bit code; D is 0000, 0 is 1010
// - early steer high when both tones valid together
// - early steer drops immediately on any loss of valid pair
// - register pair after tone-present guard time; latch code into receive register
// - guard time drive high from registration while early steer stays high
// - delayed steer flag rises after short settle delay; readable in status
// - interrupt mode: request output pulled low while delayed steer active
// - output latch updated only on delayed steer rising
// - receive register code placed on 4-bit data bus when read
// - delayed steer cleared only after tone-absent guard; shorter dropouts ignored
// - rx valid status bit set on new data, cleared by status read
// - received data interrupt held until status read
`timescale 1ns/1ps
module dtmf_rx_decode_steering #(
   parameter int GTP_CYC = dtmf_rx_pkg::TONE_PRESENT_GUARD_CYC,
   parameter int GTA_CYC = dtmf_rx_pkg::TONE_ABSENT_GUARD_CYC
) (
   // clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_reset_n,
   // limited tone inputs
   input  wire logic        i_low_tone,
   input  wire logic        i_high_tone,
   // register port
   input  wire logic [1:0]  i_addr,
   input  wire logic [3:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [3:0]  o_rdata,
   // steering pins
   output logic             o_early_steer,
   output logic             o_guard_time_drive,
   output logic             o_guard_time_drive_oe,
   // open drain request, low active: oe high pulls low
   output logic             o_request_or_progress_out_n,
   output logic             o_request_or_progress_out_oe,
   // status interrupt
   output logic             o_irq
);
   localparam int CW = 32;

   // pin synchronisers
   logic [1:0] low_sync_q;
   logic [1:0] high_sync_q;
   logic       low_prev_q;
   logic       high_prev_q;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         low_sync_q  <= 2'h0;
         high_sync_q <= 2'h0;
         low_prev_q  <= 1'b0;
         high_prev_q <= 1'b0;
      end else begin
         low_sync_q  <= {low_sync_q[0], i_low_tone};
         high_sync_q <= {high_sync_q[0], i_high_tone};
         low_prev_q  <= low_sync_q[1];
         high_prev_q <= high_sync_q[1];
      end
   end
   wire low_rise  = low_sync_q[1] & ~low_prev_q;
   wire high_rise = high_sync_q[1] & ~high_prev_q;

   function automatic logic [2:0] match_freq(input logic [dtmf_rx_pkg::PER_W-1:0] per,
                                             input logic hi);
      int f;
      int nom;
      logic [2:0] res;
      res = 3'h0;
      for (int k = 0; k < 4; k++) begin
         f   = hi ? dtmf_rx_pkg::FREQ_HIGH[k] : dtmf_rx_pkg::FREQ_LOW[k];
         nom = dtmf_rx_pkg::CLK_HZ / f;
         if (int'(per) * 100 >= nom * (100 - dtmf_rx_pkg::TOL_PCT) &&
             int'(per) * 100 <= nom * (100 + dtmf_rx_pkg::TOL_PCT))
            res = {1'b1, 2'(k)};
      end
      return res;
   endfunction

   logic [dtmf_rx_pkg::PER_W-1:0] low_cnt_q;
   logic [dtmf_rx_pkg::PER_W-1:0] high_cnt_q;
   logic [2:0]                    low_sel_q;
   logic [2:0]                    high_sel_q;
   localparam logic [dtmf_rx_pkg::PER_W-1:0] CNT_MAX = '1;
   // window match of the period just ended
   wire [2:0] low_match  = match_freq(low_cnt_q, 1'b0);
   wire [2:0] high_match = match_freq(high_cnt_q, 1'b1);
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         low_cnt_q <= '0;
         low_sel_q <= 3'h0;
      end else if (low_rise) begin
         low_sel_q <= low_match;
         low_cnt_q <= '0;
      end else if (low_cnt_q == CNT_MAX) begin
         low_sel_q <= 3'h0;
      end else begin
         low_cnt_q <= low_cnt_q + 1'b1;
      end
   end
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         high_cnt_q <= '0;
         high_sel_q <= 3'h0;
      end else if (high_rise) begin
         high_sel_q <= high_match;
         high_cnt_q <= '0;
      end else if (high_cnt_q == CNT_MAX) begin
         high_sel_q <= 3'h0;
      end else begin
         high_cnt_q <= high_cnt_q + 1'b1;
      end
   end

   function automatic logic [3:0] encode_pair(input logic [1:0] lo, input logic [1:0] hi);
      logic [3:0] c;
      if (hi == 2'h3) begin
         c = (lo == 2'h3) ? 4'h0 : 4'(4'hd + lo);
      end else if (lo == 2'h3) begin
         c = (hi == 2'h0) ? 4'hb : ((hi == 2'h1) ? 4'ha : 4'hc);
      end else begin
         c = 4'(lo * 3 + hi + 1);
      end
      return c;
   endfunction

   // early steering follows signal condition directly
   wire signal_cond = low_sel_q[2] & high_sel_q[2];
   wire [3:0] code_now = encode_pair(low_sel_q[1:0], high_sel_q[1:0]);
   assign o_early_steer = signal_cond;

   // steering state machine
   typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_ACTIVE} steer_type;
   steer_type  state_q;
   logic [CW-1:0] gcnt_q;
   logic [3:0]    pend_code_q;
   logic [3:0]    rx_data_q;
   logic          delayed_steer_q;
   logic          gt_q;
   logic [CW-1:0] settle_max;
   assign settle_max = CW'(dtmf_rx_pkg::SETTLE_CYC);

   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q         <= ST_IDLE;
         gcnt_q          <= '0;
         pend_code_q     <= 4'h0;
         delayed_steer_q <= 1'b0;
         gt_q            <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (!signal_cond) begin
                  gcnt_q <= '0;
               end else if (gcnt_q >= CW'(GTP_CYC - 1)) begin
                  gcnt_q      <= '0;
                  pend_code_q <= code_now;
                  gt_q        <= 1'b1;
                  state_q     <= ST_SETTLE;
               end else begin
                  gcnt_q <= gcnt_q + 1'b1;
               end
            end
            ST_SETTLE: begin
               gt_q <= signal_cond;
               if (gcnt_q >= settle_max - 1'b1) begin
                  gcnt_q          <= '0;
                  delayed_steer_q <= 1'b1;
                  state_q         <= ST_ACTIVE;
               end else begin
                  gcnt_q <= gcnt_q + 1'b1;
               end
            end
            ST_ACTIVE: begin
               gt_q <= gt_q & signal_cond;
               if (signal_cond) begin
                  gcnt_q <= '0;
               end else if (gcnt_q >= CW'(GTA_CYC - 1)) begin
                  gcnt_q          <= '0;
                  delayed_steer_q <= 1'b0;
                  state_q         <= ST_IDLE;
               end else begin
                  gcnt_q <= gcnt_q + 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
   assign o_guard_time_drive    = gt_q;
   assign o_guard_time_drive_oe = 1'b1;

   // latch on delayed steer rising only
   logic ds_prev_q;
   wire  ds_rise = delayed_steer_q & ~ds_prev_q;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ds_prev_q <= 1'b0;
         rx_data_q <= 4'h0;
      end else begin
         ds_prev_q <= delayed_steer_q;
         if (ds_rise)
            rx_data_q <= pend_code_q;
      end
   end

   // control and mask registers
   logic [3:0] ctrl_q;
   logic [3:0] mask_q;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_q <= dtmf_rx_pkg::CTRL_RESET;
         mask_q <= dtmf_rx_pkg::MASK_RESET;
      end else if (i_wr) begin
         if (i_addr == dtmf_rx_pkg::ADDR_CTRL)
            ctrl_q <= i_wdata;
         if (i_addr == dtmf_rx_pkg::ADDR_MASK)
            mask_q <= i_wdata;
      end
   end

   // sticky status, set wins over read clear
   logic [3:0] sticky_q;
   wire  stat_rd = i_rd && (i_addr == dtmf_rx_pkg::ADDR_STATUS);
   wire  stat_wr = i_wr && (i_addr == dtmf_rx_pkg::ADDR_STATUS);
   logic [3:0] set_ev;
   always_comb begin
      set_ev = 4'h0;
      set_ev[dtmf_rx_pkg::ST_RX_VALID_BIT] = ds_rise;
   end
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sticky_q <= 4'h0;
      end else begin
         sticky_q <= set_ev | (sticky_q & ~(stat_wr ? i_wdata : 4'h0) &
                               ~(stat_rd ? 4'h4 : 4'h0));
      end
   end
   logic [3:0] status_view;
   always_comb begin
      status_view = sticky_q;
      status_view[dtmf_rx_pkg::ST_DELAYED_STEER_BIT] = delayed_steer_q;
   end
   assign o_irq = |(sticky_q & mask_q);

   // request pin low while delayed steer in interrupt mode
   logic req_q;
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         req_q <= 1'b0;
      else
         req_q <= ctrl_q[dtmf_rx_pkg::CTRL_IRQ_MODE_BIT] &
                  (delayed_steer_q | sticky_q[dtmf_rx_pkg::ST_RX_VALID_BIT]);
   end
   assign o_request_or_progress_out_n  = 1'b0;
   assign o_request_or_progress_out_oe = req_q;

   // read data one cycle after strobe
   always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rdata <= 4'h0;
      end else if (i_rd) begin
         case (i_addr)
            dtmf_rx_pkg::ADDR_RXDATA: o_rdata <= rx_data_q;
            dtmf_rx_pkg::ADDR_STATUS: o_rdata <= status_view;
            dtmf_rx_pkg::ADDR_CTRL:   o_rdata <= ctrl_q;
            dtmf_rx_pkg::ADDR_MASK:   o_rdata <= mask_q;
            default:                  o_rdata <= 4'h0;
         endcase
      end else begin
         o_rdata <= 4'h0;
      end
   end

   // early steer false whenever a tone is unmatched
   AST_ESTEER_DROP: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (!low_sel_q[2] || !high_sel_q[2]) |-> !o_early_steer)
      else $error("early steer high without valid pair");
   AST_ESTEER_LOSS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      ((low_rise && !low_match[2]) || (high_rise && !high_match[2])) |=> !o_early_steer)
      else $error("early steer held after unmatched period");
   // matched low period with valid high raises early steer
   AST_ESTEER_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (low_rise && low_match[2] && high_sel_q[2] && !high_rise && high_cnt_q != CNT_MAX)
      |=> o_early_steer)
      else $error("early steer low with valid pair");
   AST_REG_NEEDS_COND: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_q == ST_IDLE && $past(state_q) == ST_IDLE) ##1 (state_q == ST_SETTLE)
      |-> $past(signal_cond, 2))
      else $error("registered without signal condition");
   // end of present guard registers code and drives guard
   AST_GT_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_q == ST_IDLE && signal_cond && gcnt_q == CW'(GTP_CYC - 1))
      |=> (o_guard_time_drive && pend_code_q == $past(code_now)))
      else $error("pair not registered at guard end");
   sequence settle_enter;
      state_q == ST_SETTLE && $past(state_q) == ST_IDLE;
   endsequence
   sequence settle_wait;
      !delayed_steer_q [*4] ##1 delayed_steer_q;
   endsequence
   AST_SETTLE_DELAY: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      settle_enter |-> settle_wait)
      else $error("delayed steer not after settle delay");
   AST_LATCH_ONLY_RISE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      $changed(rx_data_q) |-> $past(ds_rise))
      else $error("rx data changed without rise");
   AST_GT_FOLLOWS: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_q == ST_ACTIVE && !signal_cond) |=> !o_guard_time_drive)
      else $error("guard drive held after early steer fell");
   AST_DROPOUT: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_q == ST_ACTIVE && signal_cond) |=> delayed_steer_q)
      else $error("delayed steer cleared too early");
   // absent guard end clears delayed steer
   AST_ABSENT_GUARD: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_q == ST_ACTIVE && !signal_cond && gcnt_q == CW'(GTA_CYC - 1))
      |=> !delayed_steer_q)
      else $error("delayed steer held after absent guard");
   AST_VALID_SET: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      ds_rise |=> sticky_q[dtmf_rx_pkg::ST_RX_VALID_BIT])
      else $error("rx valid not set");
   // read clears when no new event
   AST_READ_CLEAR: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (stat_rd && !ds_rise) |=> (!sticky_q[dtmf_rx_pkg::ST_RX_VALID_BIT] && !o_irq))
      else $error("status read did not clear");
   AST_REQ_PIN: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (ctrl_q[0] && delayed_steer_q) |=> o_request_or_progress_out_oe)
      else $error("request not driven low");
   // request pin released outside interrupt mode or when delayed steer and rx valid are both low
   AST_REQ_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (!ctrl_q[dtmf_rx_pkg::CTRL_IRQ_MODE_BIT] ||
       (!delayed_steer_q && !sticky_q[dtmf_rx_pkg::ST_RX_VALID_BIT]))
      |=> !o_request_or_progress_out_oe)
      else $error("request driven without cause");
   AST_RDATA_RX: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (i_rd && i_addr == dtmf_rx_pkg::ADDR_RXDATA) |=> (o_rdata == $past(rx_data_q)))
      else $error("read data not receive register");
endmodule

//--- dtmf_rx_pkg.sv
// package for the tone receiver decode and steering block
// assumes a 10 MHz system clock and limited tone inputs from comparators
package dtmf_rx_pkg;
   localparam int CLK_HZ = 10_000_000;
   // register indices on the plain port
   localparam logic [1:0] ADDR_RXDATA = 2'h0;
   localparam logic [1:0] ADDR_STATUS = 2'h1;
   localparam logic [1:0] ADDR_CTRL   = 2'h2;
   localparam logic [1:0] ADDR_MASK   = 2'h3;
   // status bit positions
   localparam int ST_RX_VALID_BIT     = 2;
   localparam int ST_DELAYED_STEER_BIT = 3;
   // control bit positions
   localparam int CTRL_IRQ_MODE_BIT = 0;
   // reset values
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [3:0] MASK_RESET = 4'hf;
   // guard times in microseconds, converted to cycles
   localparam int TONE_PRESENT_GUARD_US = 40_000;
   localparam int TONE_ABSENT_GUARD_US  = 40_000;
   localparam int TONE_PRESENT_GUARD_CYC = TONE_PRESENT_GUARD_US * (CLK_HZ / 1_000_000);
   localparam int TONE_ABSENT_GUARD_CYC  = TONE_ABSENT_GUARD_US * (CLK_HZ / 1_000_000);
   // latch settle delay before delayed steering rises
   localparam int SETTLE_NS  = 400;
   localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // tone measurement: one tone period in cycles, tolerance in percent
   localparam int TOL_PCT = 2;
   localparam int N_LOW  = 4;
   localparam int N_HIGH = 4;
   localparam int FREQ_LOW  [N_LOW]  = '{697, 770, 852, 941};
   localparam int FREQ_HIGH [N_HIGH] = '{1209, 1336, 1477, 1633};
   localparam int PER_W = 16;
   typedef struct packed {
      logic [1:0] addr;
      logic [3:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_type;
endpackage

//--- tb.sv
// self-checking bench for the tone receiver decode and steering block
// assumes the line model drives the tone inputs; short guard counts for speed
`timescale 1ns/1ps
module tb;
   localparam int GTP = 1000;
   localparam int GTA = 25000;
   logic clk = 1'b0, reset_n = 1'b0, low_tone, high_tone, wr = 1'b0, rd = 1'b0;
   logic tone_on = 1'b0;
   logic [15:0] low_hz = 16'd941, high_hz = 16'd1336;
   logic [1:0] addr = 2'h0;
   logic [3:0] wdata = 4'h0, rdata, v;
   logic early_steer, gt_drive, gt_oe, req_n, req_oe, irq, pin;
   int err_total = 0, total_checks = 0, c, n;
   logic [3:0] exp_q [$];
   assign pin = req_oe ? req_n : 1'b1;
   initial forever #50 clk = ~clk;
   dtmf_line_model src (.i_on(tone_on), .i_low_hz(low_hz), .i_high_hz(high_hz),
      .o_low_tone(low_tone), .o_high_tone(high_tone));
   dtmf_rx_decode_steering #(.GTP_CYC(GTP), .GTA_CYC(GTA)) dut (.i_sys_clk(clk),
      .i_reset_n(reset_n), .i_low_tone(low_tone), .i_high_tone(high_tone), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_early_steer(early_steer),
      .o_guard_time_drive(gt_drive), .o_guard_time_drive_oe(gt_oe),
      .o_request_or_progress_out_n(req_n), .o_request_or_progress_out_oe(req_oe),
      .o_irq(irq));
   // reference code table, low index major
   function automatic logic [3:0] code_of(input int li, input int hi);
      logic [3:0] t [16] = '{4'h1, 4'h2, 4'h3, 4'hd, 4'h4, 4'h5, 4'h6, 4'he,
                             4'h7, 4'h8, 4'h9, 4'hf, 4'hb, 4'ha, 4'hc, 4'h0};
      return t[li * 4 + hi];
   endfunction
   function automatic logic pick(input int s);
      case (s)
         0: return early_steer;
         1: return gt_drive;
         default: return req_oe;
      endcase
   endfunction
   task automatic results();
      if (err_total == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected flag at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         err_total++;
         $display("unexpected count at %0t: %h vs %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   // bounded wait for an output to reach a level, counting cycles
   task automatic wait_sig(input int s, input logic lvl, input int lim, output int cyc);
      cyc = 0;
      while (pick(s) !== lvl && cyc < lim) begin
         tick();
         cyc++;
      end
      chk_bit(pick(s), lvl);
   endtask
   task automatic bus_wr(input logic [1:0] a, input logic [3:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [1:0] a, output logic [3:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   initial begin
      #(90_000 * 100);
      err_total++;
      results();
   end
   initial begin
      void'($urandom(71772));
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      bus_rd(dtmf_rx_pkg::ADDR_CTRL, v);
      chk(v, dtmf_rx_pkg::CTRL_RESET);
      bus_rd(dtmf_rx_pkg::ADDR_MASK, v);
      chk(v, dtmf_rx_pkg::MASK_RESET);
      bus_rd(dtmf_rx_pkg::ADDR_STATUS, v);
      chk(v, 4'h0);
      chk_bit(gt_oe, 1'b1);
      bus_wr(dtmf_rx_pkg::ADDR_CTRL, 4'h1);
      bus_rd(dtmf_rx_pkg::ADDR_CTRL, v);
      chk(v, 4'h1);
      bus_wr(dtmf_rx_pkg::ADDR_MASK, 4'h4 | 4'($urandom));
      // short burst, dropped before the present guard ends
      tone_on <= 1'b1;
      wait_sig(0, 1'b1, 22000, c);
      chk_cnt(c, 10500, 21700);
      n = 50 + $urandom_range(499);
      repeat (n) @(posedge clk);
      tone_on <= 1'b0;
      wait_sig(0, 1'b0, 400, c);
      repeat (GTP + 200) tick();
      chk_bit(req_oe, 1'b0);
      bus_rd(dtmf_rx_pkg::ADDR_STATUS, v);
      chk(v, 4'h0);
      // valid pair with a dropout inside it
      exp_q.push_back(code_of(3, 2));
      high_hz <= 16'd1477;
      tone_on <= 1'b1;
      wait_sig(0, 1'b1, 22000, c);
      chk_cnt(c, 10500, 21700);
      wait_sig(1, 1'b1, GTP + 10, c);
      chk_cnt(c, GTP - 2, GTP + 4);
      wait_sig(2, 1'b1, 10, c);
      chk_cnt(c, 3, 7);
      chk_bit(pin, 1'b0);
      chk_bit(gt_drive, 1'b1);
      chk_bit(irq, 1'b1);
      bus_rd(dtmf_rx_pkg::ADDR_RXDATA, v);
      chk(v, exp_q[0]);
      bus_wr(dtmf_rx_pkg::ADDR_MASK, 4'h0);
      tick();
      chk_bit(irq, 1'b0);
      bus_wr(dtmf_rx_pkg::ADDR_MASK, 4'h4);
      tick();
      chk_bit(irq, 1'b1);
      bus_rd(dtmf_rx_pkg::ADDR_STATUS, v);
      chk(v, 4'hc);
      chk_bit(irq, 1'b0);
      bus_rd(dtmf_rx_pkg::ADDR_STATUS, v);
      chk(v, 4'h8);
      n = 300 + $urandom_range(499);
      tone_on <= 1'b0;
      wait_sig(0, 1'b0, 400, c);
      tick();
      chk_bit(gt_drive, 1'b0);
      repeat (n) tick();
      bus_rd(dtmf_rx_pkg::ADDR_STATUS, v);
      chk(v, 4'h8);
      bus_wr(dtmf_rx_pkg::ADDR_CTRL, 4'h0);
      tick();
      chk_bit(req_oe, 1'b0);
      bus_wr(dtmf_rx_pkg::ADDR_CTRL, 4'h1);
      tone_on <= 1'b1;
      wait_sig(0, 1'b1, 22000, c);
      chk_bit(req_oe, 1'b1);
      bus_rd(dtmf_rx_pkg::ADDR_STATUS, v);
      chk(v, 4'h8);
      bus_rd(dtmf_rx_pkg::ADDR_RXDATA, v);
      chk(v, exp_q[0]);
      repeat (200) @(posedge clk);
      tone_on <= 1'b0;
      wait_sig(0, 1'b0, 400, c);
      chk_bit(gt_drive, 1'b0);
      wait_sig(2, 1'b0, GTA + 100, c);
      chk_cnt(c, GTA - 4, GTA + 8);
      chk_bit(pin, 1'b1);
      bus_rd(dtmf_rx_pkg::ADDR_STATUS, v);
      chk(v, 4'h0);
      bus_rd(dtmf_rx_pkg::ADDR_RXDATA, v);
      chk(v, exp_q.pop_front());
      results();
   end
endmodule
